// ### rsq_map.svh
// register map, field positions and timing constants of the sequencer
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH
`define RSQ_ADDR_W 12
`define RSQ_CFG_ADDR 12'h000
`define RSQ_STAT_ADDR 12'h004
`define RSQ_ORD_ADDR 12'h008
`define RSQ_KEEP_ADDR 12'h00c
`define RSQ_CFG_W 4
`define RSQ_CFG_RST 4'hf
`define RSQ_ORD_RST 8'h00
`define RSQ_OSC_LSB 0
`define RSQ_OSC_MSB 1
`define RSQ_PUDN_BIT 2
`define RSQ_DIPEN_BIT 3
`define RSQ_CNT_W 16
`define RSQ_PUD_TIME_US 72000
`define RSQ_IRC_KHZ 100
`define RSQ_PUD_TICKS ((`RSQ_PUD_TIME_US * `RSQ_IRC_KHZ) / 1000)
`define RSQ_OSC_START_CYC 16'h0400
`define RSQ_CLK_NS 25
`define RSQ_MASTER_CLEAR_IN_FILT_NS 2000
`define RSQ_MASTER_CLEAR_IN_FILT ((`RSQ_MASTER_CLEAR_IN_FILT_NS + `RSQ_CLK_NS - 1) / `RSQ_CLK_NS)
`define RSQ_FILT_W 8
`define RSQ_CLKOUT_BIT 1
`endif

// ### rsq_pkg.sv
// types shared by the reset sequencer modules
package rsq_pkg;
  typedef enum logic [2:0] {
    ST_POR_WAIT = 3'b000,
    ST_PUD = 3'b001,
    ST_OSC_START = 3'b010,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b100,
    ST_HOLD = 3'b101,
    ST_DIP_HOLD = 3'b110
  } rsq_state_t;
  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'b000,
    CAUSE_CLEAR_RUN = 3'b001,
    CAUSE_CLEAR_SLEEP = 3'b010,
    CAUSE_WATCHDOG_RESET = 3'b011,
    CAUSE_WATCHDOG_WAKE = 3'b100,
    CAUSE_SUPPLY_DIP = 3'b101
  } rsq_cause_t;
  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL = 2'b00,
    OSC_CRYSTAL = 2'b01,
    OSC_HIGH_SPEED_CRYSTAL = 2'b10,
    OSC_RESISTOR_CAP = 2'b11
  } rsq_osc_t;
endpackage

// ### rsq_count_if.sv
// start and completion signals between sequencer and edge counter
`timescale 1ns/10ps
interface rsq_count_if;
  logic start;
  logic busy;
  logic done;
  logic rise;
  modport ctl (output start, input busy, input done, input rise);
  modport cnt (input start, output busy, output done, output rise);
endinterface

// ### rsq_edge_counter.sv
// counts rising edges of a foreign clock sampled on the system clock
`timescale 1ns/10ps
`include "rsq_map.svh"
module rsq_edge_counter (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic tick_pin_in,
  input wire logic [`RSQ_CNT_W-1:0] target_in,
  rsq_count_if.cnt cnt_port
);
  import rsq_pkg::*;
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic busy_reg;
  logic done_reg;
  logic [`RSQ_CNT_W-1:0] count_reg;

  // -------------------------------------------------------------
  // two-stage synchroniser, edge taken after the second stage
  // -------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= tick_pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign cnt_port.rise = sync_reg && !prev_reg;
  assign cnt_port.busy = busy_reg;
  assign cnt_port.done = done_reg;

  // -------------------------------------------------------------
  // counter; completion is a one-cycle pulse in the system domain
  // -------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (cnt_port.start) begin
        count_reg <= '0;
        busy_reg <= 1'b1;
      end else if (busy_reg && cnt_port.rise) begin
        if (count_reg == target_in - `RSQ_CNT_W'(1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + `RSQ_CNT_W'(1);
        end
      end
    end
  end
endmodule // rsq_edge_counter

// ### rsq_reset_sequencer.sv
// reset cause tracking and power-up sequencing with an apb register file
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "rsq_map.svh"
module rsq_reset_sequencer #(
  parameter logic [`RSQ_CNT_W-1:0] PUD_TICKS =
    `RSQ_CNT_W'(`RSQ_PUD_TICKS)
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`RSQ_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic por_ok_in,
  input wire logic supply_dip_in,
  input wire logic master_clear_n_in,
  input wire logic osc_in_pin_in,
  input wire logic irc_osc_in,
  input wire logic watchdog_timeout_in,
  input wire logic sleep_req_in,
  output logic chip_reset_out,
  output logic wake_pulse_out,
  output logic timeout_flag_out,
  output logic powerdown_flag_out,
  output rsq_pkg::rsq_cause_t cause_out,
  output logic osc_out_clk_pin_out,
  output logic osc_out_clk_pin_oe_out,
  output logic osc_drive_en_out
);
  import rsq_pkg::*;

  localparam logic [`RSQ_FILT_W-1:0] FILT_CYC =
    `RSQ_FILT_W'(`RSQ_MASTER_CLEAR_IN_FILT);

  logic por_m_reg;
  logic por_s_reg;
  logic dip_m_reg;
  logic dip_s_reg;
  logic mc_m_reg;
  logic mc_s_reg;
  logic [`RSQ_FILT_W-1:0] mc_cnt_reg;
  logic master_clear_in_act_reg;
  logic [`RSQ_CFG_W-1:0] cfg_reg;
  logic [7:0] ord_reg;
  logic [7:0] keep_reg;
  logic [1:0] clk_div_reg;
  rsq_osc_t osc_mode;
  logic crystal;
  logic dip_en;
  logic pud_en;
  rsq_state_t state_reg;
  rsq_state_t state_next;
  rsq_cause_t cause_next;
  logic por_done_reg;
  logic reload;
  logic wake_evt;
  logic to_next;
  logic pd_next;
  logic hold;
  logic wr;
  logic setup;
  logic hit;
  logic err_reg;
  logic [31:0] rd_mux;

  rsq_count_if pud_if ();
  rsq_count_if ost_if ();

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      por_m_reg <= 1'b0;
      por_s_reg <= 1'b0;
      dip_m_reg <= 1'b0;
      dip_s_reg <= 1'b0;
      mc_m_reg <= 1'b1;
      mc_s_reg <= 1'b1;
    end else begin
      por_m_reg <= por_ok_in;
      por_s_reg <= por_m_reg;
      dip_m_reg <= supply_dip_in;
      dip_s_reg <= dip_m_reg;
      mc_m_reg <= master_clear_n_in;
      mc_s_reg <= mc_m_reg;
    end
  end

  // -------------------------------------------------------------
  // master-clear glitch filter
  // -------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mc_cnt_reg <= '0;
      master_clear_in_act_reg <= 1'b0;
    end else if (mc_s_reg) begin
      mc_cnt_reg <= '0;
      master_clear_in_act_reg <= 1'b0;
    end else if (mc_cnt_reg == FILT_CYC - `RSQ_FILT_W'(1)) begin
      master_clear_in_act_reg <= 1'b1;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + `RSQ_FILT_W'(1);
    end
  end

  // -------------------------------------------------------------
  // configuration decode
  // -------------------------------------------------------------
  assign osc_mode = rsq_osc_t'(cfg_reg[`RSQ_OSC_MSB:`RSQ_OSC_LSB]);
  assign crystal = (osc_mode != OSC_RESISTOR_CAP);
  assign dip_en = cfg_reg[`RSQ_DIPEN_BIT];
  assign pud_en = !cfg_reg[`RSQ_PUDN_BIT] || dip_en;

  // -------------------------------------------------------------
  // timers: internal oscillator ticks and oscillator pin cycles
  // -------------------------------------------------------------
  rsq_edge_counter u_pud_cnt (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .tick_pin_in(irc_osc_in),
    .target_in(PUD_TICKS),
    .cnt_port(pud_if.cnt)
  );

  // same pin serves a crystal or an external clock source
  rsq_edge_counter u_ost_cnt (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .tick_pin_in(osc_in_pin_in),
    .target_in(`RSQ_OSC_START_CYC),
    .cnt_port(ost_if.cnt)
  );

  // -------------------------------------------------------------
  // sequencing state machine
  // -------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cause_next = cause_out;
    to_next = timeout_flag_out;
    pd_next = powerdown_flag_out;
    pud_if.start = 1'b0;
    ost_if.start = 1'b0;
    reload = 1'b0;
    wake_evt = 1'b0;
    if (dip_en && por_done_reg && dip_s_reg &&
        state_reg != ST_DIP_HOLD) begin
      state_next = ST_DIP_HOLD;
      cause_next = CAUSE_SUPPLY_DIP;
      reload = 1'b1;
    end else begin
      case (state_reg)
        ST_POR_WAIT: begin
          if (por_s_reg) begin
            cause_next = CAUSE_POWER_ON;
            to_next = 1'b1;
            pd_next = 1'b1;
            reload = 1'b1;
            if (pud_en) begin
              state_next = ST_PUD;
              pud_if.start = 1'b1;
            end else if (crystal) begin
              state_next = ST_OSC_START;
              ost_if.start = 1'b1;
            end else begin
              state_next = ST_RUN;
            end
          end
        end
        ST_PUD: begin
          if (pud_if.done) begin
            if (crystal && cause_out == CAUSE_POWER_ON) begin
              state_next = ST_OSC_START;
              ost_if.start = 1'b1;
            end else begin
              state_next = ST_RUN;
            end
          end
        end
        ST_OSC_START: begin
          if (ost_if.done) begin
            state_next = ST_RUN;
            wake_evt = (cause_out == CAUSE_WATCHDOG_WAKE);
          end
        end
        ST_RUN: begin
          if (master_clear_in_act_reg) begin
            state_next = ST_HOLD;
            cause_next = CAUSE_CLEAR_RUN;
            reload = 1'b1;
          end else if (watchdog_timeout_in) begin
            state_next = ST_HOLD;
            cause_next = CAUSE_WATCHDOG_RESET;
            to_next = 1'b0;
            reload = 1'b1;
          end else if (sleep_req_in) begin
            state_next = ST_SLEEP;
            to_next = 1'b1;
            pd_next = 1'b0;
          end
        end
        ST_SLEEP: begin
          if (master_clear_in_act_reg) begin
            state_next = ST_HOLD;
            cause_next = CAUSE_CLEAR_SLEEP;
            to_next = 1'b1;
            pd_next = 1'b0;
            reload = 1'b1;
          end else if (watchdog_timeout_in) begin
            cause_next = CAUSE_WATCHDOG_WAKE;
            to_next = 1'b0;
            pd_next = 1'b0;
            if (crystal) begin
              state_next = ST_OSC_START;
              ost_if.start = 1'b1;
            end else begin
              state_next = ST_RUN;
              wake_evt = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!master_clear_in_act_reg) begin
            state_next = ST_RUN;
          end
        end
        ST_DIP_HOLD: begin
          if (!dip_s_reg) begin
            state_next = ST_PUD;
            pud_if.start = 1'b1;
          end
        end
        default: begin
          state_next = ST_POR_WAIT;
        end
      endcase
    end
  end

  // held low master clear keeps reset even after the timers expire
  assign hold = !(state_next == ST_RUN || state_next == ST_SLEEP) ||
    master_clear_in_act_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_POR_WAIT;
      cause_out <= CAUSE_POWER_ON;
      chip_reset_out <= 1'b1;
      wake_pulse_out <= 1'b0;
      timeout_flag_out <= 1'b1;
      powerdown_flag_out <= 1'b1;
    end else begin
      state_reg <= state_next;
      cause_out <= cause_next;
      chip_reset_out <= hold;
      wake_pulse_out <= wake_evt;
      timeout_flag_out <= to_next;
      powerdown_flag_out <= pd_next;
    end
  end

  // supply decline never reopens the power-on wait
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      por_done_reg <= 1'b0;
    end else if (state_reg == ST_POR_WAIT && por_s_reg) begin
      por_done_reg <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // oscillator pins
  // -------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_div_reg <= 2'h0;
    end else if (ost_if.rise) begin
      clk_div_reg <= clk_div_reg + 2'h1;
    end
  end

  assign osc_out_clk_pin_out = clk_div_reg[`RSQ_CLKOUT_BIT];
  assign osc_out_clk_pin_oe_out = !crystal;
  assign osc_drive_en_out = crystal;

  // -------------------------------------------------------------
  // apb slave, zero wait states
  // -------------------------------------------------------------
  assign setup = psel_in && !penable_in;
  assign wr = psel_in && penable_in && pwrite_in && hit;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && err_reg;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `RSQ_CFG_ADDR: rd_mux[`RSQ_CFG_W-1:0] = cfg_reg;
      `RSQ_STAT_ADDR: begin
        rd_mux[0] = timeout_flag_out;
        rd_mux[1] = powerdown_flag_out;
        rd_mux[4:2] = cause_out;
        rd_mux[7:5] = state_reg;
        rd_mux[8] = chip_reset_out;
      end
      `RSQ_ORD_ADDR: rd_mux[7:0] = ord_reg;
      `RSQ_KEEP_ADDR: rd_mux[7:0] = keep_reg;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup) begin
      prdata_out <= rd_mux;
      err_reg <= !hit;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_reg <= `RSQ_CFG_RST;
    end else if (wr && paddr_in == `RSQ_CFG_ADDR) begin
      cfg_reg <= pwdata_in[`RSQ_CFG_W-1:0];
    end
  end

  // ordinary register: reset state on every true reset
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ord_reg <= `RSQ_ORD_RST;
    end else if (reload) begin
      ord_reg <= `RSQ_ORD_RST;
    end else if (wr && paddr_in == `RSQ_ORD_ADDR) begin
      ord_reg <= pwdata_in[7:0];
    end
  end

  // retained register: no reset of any kind reaches it
  always_ff @(posedge clock_in) begin
    if (wr && paddr_in == `RSQ_KEEP_ADDR) begin
      keep_reg <= pwdata_in[7:0];
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_dip_release;
    state_reg == ST_DIP_HOLD && !dip_s_reg;
  endsequence

  sequence s_pud_running;
    state_reg == ST_PUD && chip_reset_out;
  endsequence

  sequence s_power_on;
    state_reg == ST_POR_WAIT && por_s_reg;
  endsequence

  a_dip_forces_pud: assert property (
    s_dip_release |=> s_pud_running)
    else $error("dip release did not start power-up delay");

  a_pud_holds_reset: assert property (
    state_reg == ST_PUD |-> chip_reset_out)
    else $error("reset released during power-up delay");

  a_por_holds_reset: assert property (
    state_reg == ST_POR_WAIT |-> chip_reset_out)
    else $error("reset released before supply good");

  a_por_flags_set: assert property (
    s_power_on |=> timeout_flag_out && powerdown_flag_out &&
      cause_out == CAUSE_POWER_ON)
    else $error("power-on flags wrong");

  a_wdt_reset_flag: assert property (
    state_reg == ST_RUN && !master_clear_in_act_reg && watchdog_timeout_in
      |=> !timeout_flag_out && chip_reset_out &&
      cause_out == CAUSE_WATCHDOG_RESET)
    else $error("watchdog reset not recorded");

  a_master_clear_in_filter_len: assert property (
    $rose(master_clear_in_act_reg) |-> $past(mc_cnt_reg) == FILT_CYC - `RSQ_FILT_W'(1))
    else $error("master clear taken before filter time");

  a_no_por_decline: assert property (
    state_reg != ST_POR_WAIT |=> state_reg != ST_POR_WAIT)
    else $error("power-on wait reentered");

  a_ord_reload: assert property (
    reload |=> ord_reg == `RSQ_ORD_RST)
    else $error("ordinary register not reloaded");

  a_wake_keeps_ord: assert property (
    state_reg == ST_SLEEP && !master_clear_in_act_reg && watchdog_timeout_in &&
      !wr |=> $stable(ord_reg) && !timeout_flag_out &&
      !powerdown_flag_out)
    else $error("watchdog wake disturbed ordinary state");

  a_clkout_divide: assert property (
    ost_if.rise && clk_div_reg == 2'h1 |=> $rose(osc_out_clk_pin_out))
    else $error("clock out not oscillator over four");

  a_start_crystal: assert property (
    $rose(state_reg == ST_OSC_START) |-> osc_drive_en_out &&
      (cause_out == CAUSE_POWER_ON || cause_next == CAUSE_WATCHDOG_WAKE))
    else $error("start count outside crystal power-on or wake");

  a_pud_skipped: assert property (
    s_power_on ##0 (!pud_en) |=> state_reg != ST_PUD)
    else $error("power-up delay ran while disabled");
endmodule // rsq_reset_sequencer

// ### rsq_far_side_model.sv
// far-side model: supply monitor, clear pin and both oscillators
`timescale 1ns/10ps
module rsq_far_side_model #(
  parameter int OSC_HALF = 2,
  parameter int IRC_HALF = 4
) (
  input wire logic clock_in,
  output logic por_ok_out,
  output logic supply_dip_out,
  output logic master_clear_n_out,
  output logic osc_in_pin_out,
  output logic irc_osc_out
);
  int osc_cnt = 0;
  int irc_cnt = 0;
  initial begin
    por_ok_out = 1'b0;
    supply_dip_out = 1'b0;
    master_clear_n_out = 1'b1;
    osc_in_pin_out = 1'b0;
    irc_osc_out = 1'b0;
  end
  // ----
  // oscillators run free, unrelated to any reset
  // ----
  always @(posedge clock_in) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    irc_cnt <= (irc_cnt == IRC_HALF - 1) ? 0 : irc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) osc_in_pin_out <= ~osc_in_pin_out;
    if (irc_cnt == IRC_HALF - 1) irc_osc_out <= ~irc_osc_out;
  end
  task automatic set_supply(input logic ok);
    @(posedge clock_in);
    por_ok_out <= ok;
  endtask
  // low clear or high dip for n cycles; clear pin pulled up after
  task automatic pulse(input bit dip, input int n);
    @(posedge clock_in);
    if (dip) supply_dip_out <= 1'b1;
    else master_clear_n_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    supply_dip_out <= 1'b0;
    master_clear_n_out <= 1'b1;
  endtask
endmodule // rsq_far_side_model

// ### reset_and_powerup_sequencer_tb.sv
// self-checking bench of the reset and power-up sequencer
`timescale 1ns/10ps
`include "rsq_map.svh"
`define CHK(nm, ex, g) begin \
  tests_run++; \
  if ((g) !== (ex)) begin \
    err_total++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, g); \
  end \
end
module reset_and_powerup_sequencer_tb;
  import rsq_pkg::*;
  localparam int PUD = 8;
  localparam int OSC_P = 4;
  localparam int IRC_P = 8;
  logic clock_in = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic wd = 1'b0;
  logic slp = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, por_ok, dip, clr_n, osc, irc, e, c, cp;
  logic chip_rst, wake, tflag, pflag, clko, clko_oe, drv_en;
  rsq_cause_t cause;
  int err_total = 0;
  int tests_run = 0;
  int rst_rises = 0;
  int wakes = 0;
  int m_to, m_pd, m_cause, m_ord, m_keep, r, w, n;
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  rsq_reset_sequencer #(.PUD_TICKS(16'(PUD))) dut (
    .clock_in(clock_in), .resetn_in(resetn), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .por_ok_in(por_ok), .supply_dip_in(dip),
    .master_clear_n_in(clr_n), .osc_in_pin_in(osc), .irc_osc_in(irc),
    .watchdog_timeout_in(wd), .sleep_req_in(slp),
    .chip_reset_out(chip_rst), .wake_pulse_out(wake),
    .timeout_flag_out(tflag), .powerdown_flag_out(pflag),
    .cause_out(cause), .osc_out_clk_pin_out(clko),
    .osc_out_clk_pin_oe_out(clko_oe), .osc_drive_en_out(drv_en));
  rsq_far_side_model #(.OSC_HALF(OSC_P / 2), .IRC_HALF(IRC_P / 2)) far (
    .clock_in(clock_in), .por_ok_out(por_ok), .supply_dip_out(dip),
    .master_clear_n_out(clr_n), .osc_in_pin_out(osc),
    .irc_osc_out(irc));
  always @(negedge clock_in) begin
    if (chip_rst === 1'b1 && c !== 1'b1) rst_rises++;
    if (wake === 1'b1) wakes++;
    c = chip_rst;
  end
  // ----
  // bus, waits and reference model
  // ----
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up();
    $display("wait limit reached");
    err_total++;
    stop_test();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) give_up();
      @(posedge clock_in);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rst(input int lim, output int cnt);
    cnt = 0;
    while (chip_rst !== 1'b0) begin
      @(negedge clock_in);
      cnt++;
      if (cnt > lim) give_up();
    end
  endtask
  function automatic bit in_win(int v, int t, int p);
    return v >= (t - 1) * p && v <= t * p + 12;
  endfunction
  task automatic model(input int k);
    m_cause = k;
    if (k != 4) m_ord = 0;
    if (k == 0 || k == 2) m_to = 1;
    if (k == 3 || k == 4) m_to = 0;
    if (k == 0) m_pd = 1;
    if (k == 2 || k == 4) m_pd = 0;
  endtask
  task automatic check_state(input string s);
    logic [31:0] x;
    x = {23'h0, 1'b0, ST_RUN, m_cause[2:0], m_pd[0], m_to[0]};
    apb(1'b0, `RSQ_STAT_ADDR, 32'h0);
    `CHK("status", x, q)
    `CHK("cause", m_cause[2:0], cause)
    `CHK("timeout", m_to[0], tflag)
    `CHK("powerdown", m_pd[0], pflag)
    apb(1'b0, `RSQ_ORD_ADDR, 32'h0);
    `CHK("ordinary", m_ord, q)
    apb(1'b0, `RSQ_KEEP_ADDR, 32'h0);
    `CHK("retained", m_keep, q)
    $display("test %s done", s);
  endtask
  task automatic put_ord();
    m_ord = $urandom_range(255, 1);
    apb(1'b1, `RSQ_ORD_ADDR, 32'(m_ord));
    r = rst_rises;
  endtask
  task automatic core(input bit go_sleep);
    @(posedge clock_in);
    if (go_sleep) slp <= 1'b1;
    else wd <= 1'b1;
    @(posedge clock_in);
    slp <= 1'b0;
    wd <= 1'b0;
  endtask
  task automatic expect_reset(input int k, input string s);
    @(negedge clock_in);
    wait_rst(6000, n);
    repeat (3) @(negedge clock_in);
    `CHK("reset count", r + 1, rst_rises)
    model(k);
    check_state(s);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (90000) @(posedge clock_in);
    give_up();
  end
  initial begin
    void'($urandom(32'hded0));
    m_keep = $urandom_range(255, 0);
    repeat (6) @(posedge clock_in);
    resetn <= 1'b1;
    apb(1'b0, `RSQ_CFG_ADDR, 32'h0);
    `CHK("config", 32'hf, q)
    repeat (20) @(negedge clock_in);
    `CHK("held before supply", 1'b1, chip_rst)
    far.set_supply(1'b1);
    wait_rst(400, n);
    `CHK("powerup", 1'b1, in_win(n, PUD, IRC_P))
    apb(1'b1, `RSQ_KEEP_ADDR, 32'(m_keep));
    model(0);
    check_state("power-on");
    `CHK("clkout enable", 1'b1, clko_oe)
    `CHK("crystal drive", 1'b0, drv_en)
    w = 0;
    cp = clko;
    for (int i = 0; i < 64; i++) begin
      @(negedge clock_in);
      if (clko === 1'b1 && cp !== 1'b1) w++;
      cp = clko;
    end
    `CHK("clkout rises", 64 / (4 * OSC_P), w)
    put_ord();
    far.pulse(1'b0, 40);
    repeat (10) @(negedge clock_in);
    `CHK("glitch", r, rst_rises)
    far.pulse(1'b0, 100);
    expect_reset(1, "clear run");
    put_ord();
    core(1'b0);
    expect_reset(3, "watchdog reset");
    put_ord();
    core(1'b1);
    w = wakes;
    core(1'b0);
    repeat (4) @(negedge clock_in);
    `CHK("wake pulse", w + 1, wakes)
    `CHK("no reset on wake", r, rst_rises)
    model(4);
    check_state("wake rc");
    put_ord();
    core(1'b1);
    far.pulse(1'b0, 100);
    expect_reset(2, "clear sleep");
    far.set_supply(1'b0);
    repeat (30) @(negedge clock_in);
    `CHK("decline", 1'b0, chip_rst)
    far.set_supply(1'b1);
    put_ord();
    far.pulse(1'b1, 10);
    expect_reset(5, "dip rc");
    `CHK("dip delay", 1'b1, in_win(n, PUD, IRC_P))
    // high-speed, low-power, then crystal mode, which stays selected
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `RSQ_CFG_ADDR, 32'((i + 2) % 3));
      @(negedge clock_in);
      `CHK("crystal drive", 1'b1, drv_en)
      `CHK("clkout off", 1'b0, clko_oe)
    end
    put_ord();
    core(1'b1);
    w = wakes;
    core(1'b0);
    expect_reset(4, "wake crystal");
    `CHK("start count", 1'b1, in_win(n, 1024, OSC_P))
    `CHK("wake pulse", w + 1, wakes)
    apb(1'b1, `RSQ_CFG_ADDR, 32'h9);
    put_ord();
    far.pulse(1'b1, 10);
    expect_reset(5, "dip crystal");
    `CHK("no start", 1'b1, in_win(n, PUD, IRC_P))
    apb(1'b1, 12'h010, 32'hffffffff);
    `CHK("slverr write", 1'b1, e)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    stop_test();
  end
endmodule // reset_and_powerup_sequencer_tb
